// ===== core/eeprom_host.sv
// host-side sequencer driving the eeprom control, address and data pins
`timescale 1ns/1ps
`default_nettype none

// Contract
// - write data driven and stable for the whole chip enable low time
// - software must erase before reprogramming a byte; programming only sets ones
// - erase and programs may follow while high supply stays on
// - address held stable around the chip enable falling edge
module eeprom_host
  import eeprom_host_pkg::*;
(
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              arst_n,
  // request side
  input  wire logic              reqValid,
  output logic                   reqReady,
  input  wire req_t              req,
  input  wire logic              vppKeep,
  output logic                   rspValid,
  output logic      [DATA_W-1:0] rspData,
  // device pins
  output pins_t                  pins,
  output logic      [ADDR_W-1:0] byte_addr,
  input  wire logic [DATA_W-1:0] data_io_in,
  output logic      [DATA_W-1:0] data_io_out,
  output logic                   data_io_oe
);
  typedef enum logic [2:0] {
    S_IDLE,
    S_SETUP,
    S_VPP,
    S_PULSE,
    S_HOLD,
    S_RECOVER
  } state_t;

  state_t            state;
  cmd_t              op;
  logic [CNT_W-1:0]  cnt;
  logic [DATA_W-1:0] busSync;

  function automatic logic [CNT_W-1:0] cyc(input int n);
    cyc = CNT_W'(n - 1);
  endfunction

  sync2 u_sync (
    .mclk   (mclk),
    .arst_n (arst_n),
    .din    (data_io_in),
    .dout   (busSync)
  );

  assign reqReady = (state == S_IDLE);

  // ****************************************
  // sequencer
  // ****************************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state <= S_IDLE;
      op    <= CMD_READ;
      cnt   <= '0;
    end else begin
      unique case (state)
        S_IDLE: begin
          if (reqValid) begin
            op    <= req.op;
            state <= S_SETUP;
            cnt   <= cyc(CYC_ADDR_SETUP);
          end
        end
        S_SETUP: begin
          if (cnt != '0) begin
            cnt <= cnt - 1'b1;
          end else if (op != CMD_READ && !pins.vppOn) begin
            state <= S_VPP;
            cnt   <= cyc(CYC_VPP_SETUP);
          end else begin
            state <= S_PULSE;
            // read strobe stretched so synced data is taken before chip enable rises
            cnt   <= (op == CMD_READ) ? cyc(CYC_ACCESS + CYC_SYNC) : cyc(CYC_PULSE);
          end
        end
        S_VPP: begin
          if (cnt != '0) begin
            cnt <= cnt - 1'b1;
          end else begin
            state <= S_PULSE;
            cnt   <= cyc(CYC_PULSE);
          end
        end
        S_PULSE: begin
          if (cnt != '0) begin
            cnt <= cnt - 1'b1;
          end else begin
            state <= S_HOLD;
            cnt   <= cyc(CYC_DATA_HOLD);
          end
        end
        S_HOLD: begin
          if (cnt != '0) begin
            cnt <= cnt - 1'b1;
          end else begin
            state <= S_RECOVER;
            cnt   <= cyc(CYC_RECOVER);
          end
        end
        S_RECOVER: begin
          if (cnt != '0) begin
            cnt <= cnt - 1'b1;
          end else begin
            state <= S_IDLE;
          end
        end
      endcase
    end
  end

  // ****************************************
  // address and write data
  // ****************************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      byte_addr   <= '0;
      data_io_out <= '0;
    end else if (state == S_IDLE && reqValid) begin
      byte_addr   <= req.addr;
      data_io_out <= req.data;
    end
  end

  // ****************************************
  // pin levels
  // ****************************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pins       <= '{chipEnable_n: 1'b1, outEnable_n: 1'b1, chipSelect: 1'b0, vppOn: 1'b0};
      data_io_oe <= 1'b0;
    end else begin
      // select only during an access, floats the device otherwise
      pins.chipSelect <= (state != S_IDLE) || reqValid;
      // program strobe on chip enable; read also falls chip enable
      pins.chipEnable_n <= !(state == S_PULSE && op != CMD_ERASE);
      // erase strobe on output enable; read data phase; never with CE under vpp
      pins.outEnable_n <= !(state == S_PULSE && op != CMD_PROGRAM);
      // bus driven from setup through hold only for programs
      data_io_oe <= (op == CMD_PROGRAM) && (state == S_SETUP || state == S_VPP
                    || state == S_PULSE || state == S_HOLD);
      // supply stays raised between ops when asked, else dropped in idle; a read request in idle always drops it
      if (state == S_VPP) begin
        pins.vppOn <= 1'b1;
      end else if (state == S_IDLE && !(vppKeep && reqValid && req.op != CMD_READ)
                   && !vppKeep) begin
        pins.vppOn <= 1'b0;
      end else if (state == S_IDLE && reqValid && req.op == CMD_READ) begin
        pins.vppOn <= 1'b0;
      end
    end
  end

  // ****************************************
  // read capture
  // ****************************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rspValid <= 1'b0;
      rspData  <= '0;
    end else begin
      rspValid <= 1'b0;
      // latch only lasts while chip enable is low; float time is not guaranteed
      if (state == S_PULSE && cnt == '0 && op == CMD_READ) begin
        rspData  <= busSync;
        rspValid <= 1'b1;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  chk_no_both_low: assert property (@(posedge mclk) disable iff (!arst_n)
    pins.vppOn |-> (pins.chipEnable_n || pins.outEnable_n))
    else $error("both enables low under high supply");
  chk_bus_float_read: assert property (@(posedge mclk) disable iff (!arst_n)
    !pins.outEnable_n |-> !data_io_oe)
    else $error("bus driven while device may drive");
  chk_data_stable: assert property (@(posedge mclk) disable iff (!arst_n)
    (!pins.chipEnable_n && data_io_oe) |-> $stable(data_io_out))
    else $error("write data changed during strobe");
  chk_addr_stable: assert property (@(posedge mclk) disable iff (!arst_n)
    $fell(pins.chipEnable_n) |-> $stable(byte_addr) && $past(pins.chipSelect))
    else $error("address moved at chip enable fall");
  chk_prog_oe_high: assert property (@(posedge mclk) disable iff (!arst_n)
    (!pins.chipEnable_n && pins.vppOn) |-> (pins.outEnable_n && data_io_oe))
    else $error("program strobe without data or with oe low");
  chk_erase_ce_high: assert property (@(posedge mclk) disable iff (!arst_n)
    (!pins.outEnable_n && pins.vppOn) |-> (pins.chipEnable_n && !data_io_oe))
    else $error("erase strobe with ce low or bus driven");
  chk_read_nominal: assert property (@(posedge mclk) disable iff (!arst_n)
    (!pins.outEnable_n && !pins.chipEnable_n) |-> (!pins.vppOn && pins.chipSelect))
    else $error("read phase not at nominal supply");
  chk_sel_idle: assert property (@(posedge mclk) disable iff (!arst_n)
    (state == S_IDLE && !reqValid) |=> !pins.chipSelect)
    else $error("device left selected when idle");
  chk_rsp_timing: assert property (@(posedge mclk) disable iff (!arst_n)
    rspValid |-> $past(state == S_PULSE) && op == CMD_READ)
    else $error("read response at wrong time");

  cov_read: cover property (@(posedge mclk) disable iff (!arst_n) rspValid);
  cov_erase: cover property (@(posedge mclk) disable iff (!arst_n)
    $fell(pins.outEnable_n) && pins.vppOn);
  cov_program: cover property (@(posedge mclk) disable iff (!arst_n)
    $fell(pins.chipEnable_n) && pins.vppOn);
endmodule
`default_nettype wire

// ===== core/eeprom_host_pkg.sv
// shared constants and carrier types for the eeprom pin controller
package eeprom_host_pkg;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam int CLK_MHZ = 50;
  // timing figures in their own units
  localparam int T_ADDR_SETUP_NS = 200;
  localparam int T_ACCESS_NS = 650;
  localparam int T_DATA_HOLD_NS = 200;
  localparam int T_VPP_SETUP_US = 5;
  localparam int T_PULSE_MS = 1;
  localparam int T_RECOVER_NS = 300;
  localparam int CYC_ADDR_SETUP = (T_ADDR_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int CYC_ACCESS = (T_ACCESS_NS * CLK_MHZ + 999) / 1000;
  localparam int CYC_DATA_HOLD = (T_DATA_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int CYC_VPP_SETUP = T_VPP_SETUP_US * CLK_MHZ;
  localparam int CYC_PULSE = T_PULSE_MS * 1000 * CLK_MHZ;
  localparam int CYC_RECOVER = (T_RECOVER_NS * CLK_MHZ + 999) / 1000;
  // two sync flops plus the read capture edge that samples their output
  localparam int CYC_SYNC = 3;
  localparam int CNT_W = 20;

  typedef enum logic [1:0] {
    CMD_READ,
    CMD_ERASE,
    CMD_PROGRAM
  } cmd_t;

  typedef struct packed {
    cmd_t              op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } req_t;

  typedef struct packed {
    logic chipEnable_n;
    logic outEnable_n;
    logic chipSelect;
    logic vppOn;
  } pins_t;
endpackage

// ===== core/sync2.sv
// two-flop synchroniser for the data bus input
`timescale 1ns/1ps
`default_nettype none
module sync2
  import eeprom_host_pkg::*;
(
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              arst_n,
  // bus
  input  wire logic [DATA_W-1:0] din,
  output logic      [DATA_W-1:0] dout
);
  logic [DATA_W-1:0] stage;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      stage <= '0;
      dout  <= '0;
    end else begin
      stage <= din;
      dout  <= stage;
    end
  end
endmodule
`default_nettype wire

// ===== verification/eeprom_dev_model.sv
// far-side model of the 1024 x 8 eeprom
`timescale 1ns/1ps
`default_nettype none
module eeprom_dev_model
  import eeprom_host_pkg::*;
#(
  parameter int FLOAT_CYC = 15
)
(
  // clock and pins
  input  wire logic              mclk,
  input  wire pins_t             pins,
  input  wire logic [ADDR_W-1:0] byte_addr,
  input  wire logic [DATA_W-1:0] busIn,
  input  wire logic              hostOe,
  // drive and fault count
  output logic      [DATA_W-1:0] devOut,
  output logic                   devOe,
  output var int                 faults
);
  // ****
  // array and strobes
  // ****
  logic [DATA_W-1:0] mem [1024];
  logic [DATA_W-1:0] progData;
  logic [ADDR_W-1:0] addrHeld;
  logic [ADDR_W-1:0] prevAddr;
  pins_t             prev = 4'hC;
  logic              progOn = 1'b0;
  int                floatCnt = 0;
  int                accCnt = 0;
  logic [DATA_W-1:0] latched;
  logic              ceLow;
  logic              oeLow;
  logic              start;
  logic              drive;

  assign ceLow = pins.chipSelect && !pins.chipEnable_n;
  assign oeLow = pins.chipSelect && !pins.outEnable_n;
  // enable fall, or select rise with enable already low
  assign start = ceLow && (prev.chipEnable_n || !prev.chipSelect);
  assign drive = ceLow && oeLow && !pins.vppOn;
  // outputs take a while to float after disable, like a real part
  assign devOe = drive || (floatCnt > 0 && pins.chipSelect && !pins.vppOn);
  // garbage until the access time has run, so an early sample is caught
  assign devOut = (accCnt == 0) ? latched : ~latched;

  initial begin
    for (int i = 0; i < 1024; i++) begin
      mem[i] = DATA_W'(i * 37 + 5);
    end
    faults = 0;
  end

  always @(posedge mclk) begin
    prev <= pins;
    prevAddr <= byte_addr;
    floatCnt <= drive ? FLOAT_CYC : (floatCnt > 0 ? floatCnt - 1 : 0);
    // start is seen one edge after the enable falls
    accCnt <= start ? CYC_ACCESS - 2 : (accCnt > 0 ? accCnt - 1 : 0);
    if (start) begin
      addrHeld <= byte_addr;
      if (byte_addr !== prevAddr) faults <= faults + 1;
    end
    if (start && !pins.vppOn) latched <= mem[byte_addr];
    if (start && pins.vppOn && pins.outEnable_n) begin
      progOn <= 1'b1;
      progData <= busIn;
    end
    if (progOn && ceLow && busIn !== progData) faults <= faults + 1;
    if (progOn && !ceLow) begin
      mem[addrHeld] <= mem[addrHeld] | progData;
      progOn <= 1'b0;
    end
    if (pins.vppOn && oeLow && pins.chipEnable_n
        && (prev.outEnable_n || !prev.chipSelect)) begin
      for (int i = 0; i < 1024; i++) begin
        mem[i] <= '0;
      end
    end
    if (pins.vppOn && ceLow && oeLow) faults <= faults + 1;
    if (hostOe && devOe) faults <= faults + 1;
  end
endmodule
`default_nettype wire

// ===== verification/eeprom_host_bench.sv
// self-checking bench for the eeprom pin controller
`timescale 1ns/1ps
`default_nettype none
module eeprom_host_bench
  import eeprom_host_pkg::*;
;
  // ****
  // stimulus, model and checks
  // ****
  logic              mclk = 1'b0;
  logic              arst_n = 1'b0;
  logic              reqValid = 1'b0;
  logic              vppKeep = 1'b0;
  req_t              req = '0;
  logic              reqReady;
  logic              rspValid;
  logic [DATA_W-1:0] rspData;
  pins_t             pins;
  logic [ADDR_W-1:0] byte_addr;
  logic [DATA_W-1:0] dataOut;
  logic              dataOe;
  logic [DATA_W-1:0] bus;
  logic [DATA_W-1:0] lastBus = 8'h00;
  logic [DATA_W-1:0] devOut;
  logic              devOe;
  int                faults;
  int                numErrors = 0;
  int                checkCount = 0;
  logic [DATA_W-1:0] expMem [1024];
  logic [ADDR_W-1:0] pa;
  logic [DATA_W-1:0] pd;

  always #10 mclk = ~mclk;
  // undriven bus shows the inverse of its last value
  assign bus = dataOe ? dataOut : devOe ? devOut : ~lastBus;
  always @(posedge mclk) lastBus <= bus;

  eeprom_host u_dut (.mclk(mclk), .arst_n(arst_n), .reqValid(reqValid),
    .reqReady(reqReady), .req(req), .vppKeep(vppKeep), .rspValid(rspValid),
    .rspData(rspData), .pins(pins), .byte_addr(byte_addr), .data_io_in(bus),
    .data_io_out(dataOut), .data_io_oe(dataOe));
  eeprom_dev_model u_dev (.mclk(mclk), .pins(pins), .byte_addr(byte_addr),
    .busIn(bus), .hostOe(dataOe), .devOut(devOut), .devOe(devOe), .faults(faults));

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checkCount++;
    if (seen !== exp) begin
      numErrors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic results();
    if (numErrors == 0 && checkCount > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic waitReady(input int limit);
    int n;
    n = 0;
    while (reqReady !== 1'b1 && n < limit) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n >= limit) begin
      numErrors++;
      results();
    end
  endtask

  task automatic doOp(input cmd_t op, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    waitReady(2000);
    @(negedge mclk);
    reqValid = 1'b1;
    req = '{op: op, addr: a, data: d};
    @(negedge mclk);
    reqValid = 1'b0;
    n = 0;
    while (op == CMD_READ && rspValid !== 1'b1 && n < 300) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n >= 300) begin
      numErrors++;
      results();
    end
    if (op == CMD_READ) check("read data", rspData, expMem[a]);
  endtask

  initial begin
    void'($urandom(32'h1941));
    for (int i = 0; i < 1024; i++) begin
      expMem[i] = 8'(i * 37 + 5);
    end
    repeat (16) @(posedge mclk);
    check("idle pins", {pins, dataOe}, 16'h0018);
    @(negedge mclk);
    arst_n = 1'b1;
    // corner addresses first, then random ones
    for (int k = 0; k < 8; k++) begin
      doOp(CMD_READ, (k == 0) ? 10'h000 : (k == 1) ? 10'h3FF : 10'($urandom), 8'h00);
    end
    @(negedge mclk);
    vppKeep = 1'b1;
    doOp(CMD_ERASE, 10'($urandom), 8'($urandom));
    for (int i = 0; i < 1024; i++) begin
      expMem[i] = 8'h00;
    end
    waitReady(60000);
    check("supply kept", 16'(pins.vppOn), 16'h0001);
    pa = 10'($urandom);
    pd = 8'($urandom);
    doOp(CMD_PROGRAM, pa, pd);
    expMem[pa] = expMem[pa] | pd;
    waitReady(60000);
    @(negedge mclk);
    vppKeep = 1'b0;
    doOp(CMD_READ, pa, 8'h00);
    doOp(CMD_READ, pa ^ 10'h001, 8'h00);
    doOp(CMD_READ, 10'($urandom), 8'h00);
    check("device faults", 16'(faults), 16'h0000);
    results();
  end
endmodule
`default_nettype wire
